// >>> hw/aic_irq_status.sv
// Interrupt source status, identification and data configuration registers.
// Assumes detection engines and data registers on clk_i drive the event
// flags and the read-clear pulses; software reaches registers over APB.
//
// Contract
// - Transient flag sets on engine event, enabled
// - Orientation flag sets on new orientation, enabled
// - Tap flag sets on pulse event, enabled
// - Fall/motion flag sets on its event, enabled
// - Data-ready flag sets on new or overwritten sample, enabled
// - Data-ready clears only after X, Y, Z read
// - All source flags are zero after reset
// - Read-only identification register returns fixed code
// - High-pass bit selects filtered or raw output
// - Full-scale field selects 2, 4, 8 g
// - Reset selects 2 g, filter off
// - Configuration register is readable and writable
// - Flags set only on rising condition edge
module aic_irq_status
  import aic_pkg::*;
#(
  parameter logic [REG_W-1:0] PART_ID  = PART_ID_D,  // Arbitrary identification value.
  parameter int               SAMPLE_W = DATA_W      // Sample width.
)
(
  input  wire logic                clk_i,                          // System clock.
  input  wire logic                rst_i,                          // Async reset, high.
  input  wire logic [APB_AW-1:0]   paddr_i,                        // APB address.
  input  wire logic                psel_i,                         // APB select.
  input  wire logic                penable_i,                      // APB enable.
  input  wire logic                pwrite_i,                       // APB direction.
  input  wire logic [APB_DW-1:0]   pwdata_i,                       // APB write data.
  output logic      [APB_DW-1:0]   prdata_o,                       // APB read data.
  output logic                     pready_o,                       // APB ready.
  output logic                     pslverr_o,                      // APB error.
  input  wire logic                transient_event_active_i,       // Transient event.
  input  wire logic                new_orientation_flag_i,         // Orientation changed.
  input  wire logic                tap_event_active_i,             // Pulse event.
  input  wire logic                fall_motion_event_active_i,     // Fall or motion event.
  input  wire logic                all_axes_new_sample_i,          // New sample on all axes.
  input  wire logic                all_axes_overwrite_i,           // Sample overwritten.
  input  wire logic                transient_source_reg_read_i,    // Source read pulse.
  input  wire logic                orientation_status_reg_read_i,  // Status read pulse.
  input  wire logic                tap_source_reg_read_i,          // Source read pulse.
  input  wire logic                fall_motion_source_reg_read_i,  // Source read pulse.
  input  wire logic                xyz_data_read_i,                // All axes read pulse.
  input  wire logic [SAMPLE_W-1:0] raw_sample_i,                   // Unfiltered sample.
  input  wire logic [SAMPLE_W-1:0] hp_sample_i,                    // High-pass sample.
  input  wire logic                sample_valid_i,                 // Sample strobe.
  output logic      [SAMPLE_W-1:0] out_sample_o,                   // Sample to data regs.
  output logic                     out_valid_o,                    // Output sample strobe.
  output logic      [1:0]          full_scale_select_o,            // Range for formatting.
  output logic                     highpass_output_enable_o,       // Filter selection.
  output logic                     irq_o                           // Level interrupt.
);

  // ******************************************************************
  // Elaboration check.
  // ******************************************************************
  if (SAMPLE_W < 1 || SAMPLE_W > 16)
  begin : g_chk
    $error("SAMPLE_W must lie between 1 and 16");
  end

  // ******************************************************************
  // Declarations.
  // ******************************************************************
  aic_reg_if rif ();                        // Slave to register file link.
  logic [REG_W-1:0]    cond_w;              // Gated source conditions.
  logic [REG_W-1:0]    clr_w;               // Read-clear pulses.
  logic [REG_W-1:0]    set_w;               // Set pulses of the flags.
  logic [REG_W-1:0]    flag_w;              // Source flags.
  logic [REG_W-1:0]    cfg_q, cfg_d;        // Data configuration.
  logic [REG_W-1:0]    ien_q, ien_d;        // Interrupt enables.
  logic [REG_W-1:0]    ists_q, ists_d;      // Sticky event status.
  logic [REG_W-1:0]    imsk_q, imsk_d;      // Event mask.
  logic                irq_q, irq_d;        // Interrupt output.
  logic [SAMPLE_W-1:0] smp_q, smp_d;        // Output sample.
  logic                sval_q, sval_d;      // Output sample strobe.

  // APB front end.
  aic_apb_slave u_apb
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .paddr_i   (paddr_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .rif       (rif)
  );

  // ******************************************************************
  // Source conditions and their clears.
  // ******************************************************************
  always_comb
  begin
    cond_w            = '0;
    clr_w             = '0;
    cond_w[BIT_TRANS]  = transient_event_active_i & ien_q[BIT_TRANS];
    cond_w[BIT_ORIENT] = new_orientation_flag_i & ien_q[BIT_ORIENT];
    cond_w[BIT_TAP]    = tap_event_active_i & ien_q[BIT_TAP];
    cond_w[BIT_FM]     = fall_motion_event_active_i & ien_q[BIT_FM];
    cond_w[BIT_DRDY]   = (all_axes_new_sample_i | all_axes_overwrite_i)
                         & ien_q[BIT_DRDY];
    clr_w[BIT_TRANS]   = transient_source_reg_read_i;
    clr_w[BIT_ORIENT]  = orientation_status_reg_read_i;
    clr_w[BIT_TAP]     = tap_source_reg_read_i;
    clr_w[BIT_FM]      = fall_motion_source_reg_read_i;
    clr_w[BIT_DRDY]    = xyz_data_read_i;
  end

  // One edge-set flag per implemented source bit; the rest read zero.
  for (genvar i = 0; i < REG_W; i++)
  begin : g_src
    if (SRC_MASK[i])
    begin : g_on
      aic_edge_flag u_flag
      (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cond_i (cond_w[i]),
        .clr_i  (clr_w[i]),
        .set_o  (set_w[i]),
        .flag_o (flag_w[i])
      );
    end
    else
    begin : g_off
      assign set_w[i]  = 1'b0;
      assign flag_w[i] = 1'b0;
    end
  end

  // ******************************************************************
  // Register read multiplexer.
  // ******************************************************************
  always_comb
  begin
    rif.hit   = 1'b1;
    rif.rdata = '0;
    case (rif.idx)
      IDX_SRC:  rif.rdata = flag_w;
      IDX_ID:   rif.rdata = PART_ID;
      IDX_CFG:  rif.rdata = cfg_q;
      IDX_IEN:  rif.rdata = ien_q;
      IDX_ISTS: rif.rdata = ists_q;
      IDX_IMSK: rif.rdata = imsk_q;
      default:  rif.hit   = 1'b0;     // Unmapped: slave answers with an error.
    endcase
  end

  // ******************************************************************
  // Register writes, sticky status, interrupt and sample path.
  // ******************************************************************
  always_comb
  begin
    cfg_d  = cfg_q;
    ien_d  = ien_q;
    imsk_d = imsk_q;
    ists_d = ists_q;
    // Identification and source indices fall through: writes have no effect.
    if (rif.wr && rif.idx == IDX_CFG)
    begin
      cfg_d = rif.wdata & CFG_WMASK;
      // A reserved range code keeps the previous range.
      if (rif.wdata[CFG_FS_HI:CFG_FS_LO] == FS_RSVD)
      begin
        cfg_d[CFG_FS_HI:CFG_FS_LO] = cfg_q[CFG_FS_HI:CFG_FS_LO];
      end
    end
    if (rif.wr && rif.idx == IDX_IEN)
    begin
      ien_d = rif.wdata & SRC_MASK;
    end
    if (rif.wr && rif.idx == IDX_IMSK)
    begin
      imsk_d = rif.wdata & SRC_MASK;
    end
    if (rif.wr && rif.idx == IDX_ISTS)
    begin
      ists_d = ists_q & ~rif.wdata;
    end
    // A new event wins over a clear in the same cycle.
    ists_d = ists_d | set_w;
    irq_d  = |(ists_d & imsk_d);
    // Filtered or raw samples go to the output data registers.
    sval_d = sample_valid_i;
    smp_d  = smp_q;
    if (sample_valid_i)
    begin
      smp_d = cfg_q[CFG_HPF] ? hp_sample_i : raw_sample_i;
    end
  end

  // Registers of the block.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_q  <= CFG_RST;
      ien_q  <= REG_RST;
      ists_q <= REG_RST;
      imsk_q <= REG_RST;
      irq_q  <= 1'b0;
      smp_q  <= '0;
      sval_q <= 1'b0;
    end
    else
    begin
      cfg_q  <= cfg_d;
      ien_q  <= ien_d;
      ists_q <= ists_d;
      imsk_q <= imsk_d;
      irq_q  <= irq_d;
      smp_q  <= smp_d;
      sval_q <= sval_d;
    end
  end

  // Outputs come straight from registers.
  assign out_sample_o             = smp_q;
  assign out_valid_o              = sval_q;
  assign full_scale_select_o      = cfg_q[CFG_FS_HI:CFG_FS_LO];
  assign highpass_output_enable_o = cfg_q[CFG_HPF];
  assign irq_o                    = irq_q;

  // ******************************************************************
  // Assertions.
  // ******************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_trans_set;
    $rose(cond_w[BIT_TRANS]) |=> flag_w[BIT_TRANS];
  endproperty
  a_trans_set: assert property (p_trans_set) else $error("transient flag not set");

  property p_orient_set;
    $rose(cond_w[BIT_ORIENT]) |=> flag_w[BIT_ORIENT];
  endproperty
  a_orient_set: assert property (p_orient_set) else $error("orientation flag not set");

  property p_tap_set;
    (tap_event_active_i && ien_q[BIT_TAP] && !$past(cond_w[BIT_TAP])) |=> flag_w[BIT_TAP];
  endproperty
  a_tap_set: assert property (p_tap_set) else $error("tap flag not set");

  property p_fm_clr;
    (flag_w[BIT_FM] && fall_motion_source_reg_read_i && !set_w[BIT_FM]) |=> !flag_w[BIT_FM];
  endproperty
  a_fm_clr: assert property (p_fm_clr) else $error("fall flag not cleared");

  property p_drdy_set;
    $rose((all_axes_new_sample_i | all_axes_overwrite_i) & ien_q[BIT_DRDY])
      |=> flag_w[BIT_DRDY] ##1 ists_q[BIT_DRDY];
  endproperty
  a_drdy_set: assert property (p_drdy_set) else $error("data ready flag not set");

  property p_drdy_hold;
    (flag_w[BIT_DRDY] && !xyz_data_read_i) |=> flag_w[BIT_DRDY];
  endproperty
  a_drdy_hold: assert property (p_drdy_hold) else $error("data ready lost early");

  property p_id_read;
    (psel_i && !penable_i && !pwrite_i && paddr_i == {IDX_ID, 2'b00})
      |=> pready_o && !pslverr_o && prdata_o[REG_W-1:0] == PART_ID;
  endproperty
  a_id_read: assert property (p_id_read) else $error("identification read wrong");

  property p_hpf_sel;
    sample_valid_i |=> out_valid_o &&
      out_sample_o == ($past(cfg_q[CFG_HPF]) ? $past(hp_sample_i) : $past(raw_sample_i));
  endproperty
  a_hpf_sel: assert property (p_hpf_sel) else $error("wrong sample source");

  property p_fs_legal;
    full_scale_select_o != FS_RSVD;
  endproperty
  a_fs_legal: assert property (p_fs_legal) else $error("reserved range selected");

  property p_cfg_write;
    (rif.wr && rif.idx == IDX_CFG && rif.wdata[CFG_FS_HI:CFG_FS_LO] != FS_RSVD)
      |=> cfg_q == ($past(rif.wdata) & CFG_WMASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("configuration not written");

  property p_edge_only;
    $rose(flag_w[BIT_TRANS]) |-> $past(cond_w[BIT_TRANS]) && !$past(cond_w[BIT_TRANS], 2);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("flag set without edge");

  property p_src_ro;
    (rif.wr && rif.idx == IDX_SRC && set_w == '0 && clr_w == '0) |=> $stable(flag_w);
  endproperty
  a_src_ro: assert property (p_src_ro) else $error("source register changed");

  c_irq:     cover property (irq_o);
  c_drdy_rc: cover property (flag_w[BIT_DRDY] ##1 xyz_data_read_i ##1 !flag_w[BIT_DRDY]);
  c_hpf:     cover property (highpass_output_enable_o && out_valid_o);

endmodule : aic_irq_status

// >>> include/aic_pkg.sv
// Package of the interrupt-source and data-configuration register block.
// Assumes a single clock domain; shared by the top, the slave and the interface.
package aic_pkg;

  // ******************************************************************
  // Register indices; the APB byte address is four times the index.
  // ******************************************************************
  localparam logic [5:0] IDX_SRC  = 6'h0C;  // Interrupt source status, read only.
  localparam logic [5:0] IDX_ID   = 6'h0D;  // Part identification, read only.
  localparam logic [5:0] IDX_CFG  = 6'h0E;  // Output data configuration.
  localparam logic [5:0] IDX_IEN  = 6'h20;  // Per-function interrupt enables.
  localparam logic [5:0] IDX_ISTS = 6'h21;  // Sticky event status, write one to clear.
  localparam logic [5:0] IDX_IMSK = 6'h22;  // Mask gating sticky events onto irq_o.

  // ******************************************************************
  // Field positions and masks.
  // ******************************************************************
  localparam int BIT_TRANS  = 5;  // Transient function.
  localparam int BIT_ORIENT = 4;  // Orientation change.
  localparam int BIT_TAP    = 3;  // Pulse (tap) function.
  localparam int BIT_FM     = 2;  // Freefall or motion.
  localparam int BIT_DRDY   = 0;  // Data ready.
  localparam logic [7:0] SRC_MASK  = 8'h3D;  // Implemented source bits.
  localparam int         CFG_HPF   = 4;      // High-pass output enable bit.
  localparam int         CFG_FS_LO = 0;      // Full-scale field, low bit.
  localparam int         CFG_FS_HI = 1;      // Full-scale field, high bit.
  localparam logic [7:0] CFG_WMASK = 8'h13;  // Writable configuration bits.

  // ******************************************************************
  // Reset values and widths.
  // ******************************************************************
  localparam logic [7:0] CFG_RST   = 8'h00;  // Two g range, filter off.
  localparam logic [7:0] REG_RST   = 8'h00;  // Enables, status and mask.
  localparam logic [7:0] PART_ID_D = 8'h5C;  // Arbitrary identification value.
  localparam int         DATA_W    = 12;     // Sample width.
  localparam int         REG_W     = 8;      // Register width.
  localparam int         APB_AW    = 8;      // APB address width.
  localparam int         APB_DW    = 32;     // APB data width.

  // Full-scale selections.
  localparam logic [1:0] FS_2G   = 2'b00;
  localparam logic [1:0] FS_4G   = 2'b01;
  localparam logic [1:0] FS_8G   = 2'b10;
  localparam logic [1:0] FS_RSVD = 2'b11;

endpackage : aic_pkg

// >>> include/aic_reg_if.sv
// Interface between the APB slave and the register file of the block.
// Assumes both ends share one clock; write is a one-cycle pulse.
interface aic_reg_if;
  import aic_pkg::*;
  logic             wr;     // Write strobe, one cycle, at the access edge.
  logic [5:0]       idx;    // Register index decoded from the address.
  logic [REG_W-1:0] wdata;  // Write data, low byte of the bus.
  logic [REG_W-1:0] rdata;  // Read data for the current index.
  logic             hit;    // Index names a register.

  // Bus side drives the request and reads the answer.
  modport bus  (output wr, idx, wdata, input rdata, hit);
  // Register side answers the request.
  modport regs (input wr, idx, wdata, output rdata, hit);
endinterface : aic_reg_if

// >>> hw/aic_edge_flag.sv
// One interrupt source flag, set on a rising edge of its condition.
// Assumes the condition and the clear pulse come from logic on clk_i.
module aic_edge_flag
(
  input  wire logic clk_i,   // System clock.
  input  wire logic rst_i,   // Asynchronous reset, active high.
  input  wire logic cond_i,  // Source condition, already gated by its enable.
  input  wire logic clr_i,   // Clear pulse from reading the source register.
  output logic      set_o,   // Pulse in the cycle the flag is set.
  output logic      flag_o   // Flag state.
);

  logic prev_q, prev_d;  // Condition in the previous cycle.
  logic flag_q, flag_d;  // Flag state.

  // ******************************************************************
  // Next state: a set beats a clear in the same cycle.
  // ******************************************************************
  always_comb
  begin
    prev_d = cond_i;
    set_o  = cond_i & ~prev_q;
    flag_d = set_o | (flag_q & ~clr_i);
  end

  // Registers; all flags start clear.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule : aic_edge_flag

// >>> hw/aic_apb_slave.sv
// APB slave front end with one wait-free access phase.
// Assumes an APB3 master on clk_i; answers unmapped or misaligned with pslverr.
module aic_apb_slave
  import aic_pkg::*;
(
  input  wire logic              clk_i,      // System clock.
  input  wire logic              rst_i,      // Asynchronous reset, active high.
  input  wire logic [APB_AW-1:0] paddr_i,    // Byte address.
  input  wire logic              psel_i,     // Select.
  input  wire logic              penable_i,  // Access phase.
  input  wire logic              pwrite_i,   // Direction, high for write.
  input  wire logic [APB_DW-1:0] pwdata_i,   // Write data.
  output logic      [APB_DW-1:0] prdata_o,   // Read data, registered.
  output logic                   pready_o,   // Ready, registered.
  output logic                   pslverr_o,  // Error, registered.
  aic_reg_if.bus                 rif         // Register side.
);

  logic [APB_DW-1:0] prdata_q, prdata_d;  // Captured read data.
  logic              pready_q, pready_d;  // High in the access phase.
  logic              perr_q, perr_d;      // Error answer.
  logic              setup;               // Setup cycle of a transfer.

  // ******************************************************************
  // Decode: the answer is prepared in the setup cycle.
  // ******************************************************************
  always_comb
  begin
    setup    = psel_i & ~penable_i;
    pready_d = setup;
    perr_d   = setup & (~rif.hit | (paddr_i[1:0] != 2'b00));
    prdata_d = '0;
    if (setup & ~pwrite_i)
    begin
      prdata_d = {{(APB_DW-REG_W){1'b0}}, rif.rdata};
    end
  end

  // Registers of the answer.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      perr_q   <= perr_d;
    end
  end

  // A write lands only at the completing edge of an error-free access.
  assign rif.idx   = paddr_i[7:2];
  assign rif.wdata = pwdata_i[REG_W-1:0];
  assign rif.wr    = psel_i & penable_i & pwrite_i & pready_q & ~perr_q;
  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = perr_q;

endmodule : aic_apb_slave

// >>> dv/aic_host_model.sv
// Host processor model: an APB master that runs one transfer at a time.
// Assumes a zero or more wait state slave on clk_i that answers with pready.
module aic_host_model
  import aic_pkg::*;
(
  input  wire logic              clk_i,      // System clock.
  output logic      [APB_AW-1:0] paddr_o,    // Byte address.
  output logic                   psel_o,     // Select.
  output logic                   penable_o,  // Access phase.
  output logic                   pwrite_o,   // Direction, high for write.
  output logic      [APB_DW-1:0] pwdata_o,   // Write data.
  input  wire logic [APB_DW-1:0] prdata_i,   // Read data.
  input  wire logic              pready_i,   // Ready.
  input  wire logic              pslverr_i   // Error.
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus idles at zero so the slave sees no request before reset ends.
  initial
  begin
    paddr_o = '0;
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    pwdata_o = '0;
  end

  // One transfer; the request holds until pready is sampled, ok stays low on a hang.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ok);
    ok = 1'b0;
    @(posedge clk_i);
    paddr_o <= a;
    pwrite_o <= w;
    pwdata_o <= d;
    psel_o <= 1'b1;
    @(posedge clk_i);
    penable_o <= 1'b1;
    for (int n = 0; n < 16 && ok == 1'b0; n++)
    begin
      @(posedge clk_i);
      if (pready_i === 1'b1)
      begin
        rd = prdata_i;
        err = pslverr_i;
        ok = 1'b1;
      end
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer
endmodule : aic_host_model

// >>> dv/aic_irq_status_bench.sv
// Self-checking bench of the interrupt source and data configuration block.
// Assumes the package, the design and the host model are compiled first.
module aic_irq_status_bench
  import aic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [APB_AW-1:0] paddr_i;
  logic [APB_DW-1:0] pwdata_i, prdata_o, rd;
  logic [3:0]        ev_q, clr_q;  // Engines: transient, orientation, tap, fall/motion.
  logic              new_q, ovw_q, xyz_q, val_q, er, ok;
  logic [DATA_W-1:0] raw_q, hp_q, out_sample_o;
  logic              out_valid_o, highpass_output_enable_o, irq_o;
  logic [1:0]        full_scale_select_o;
  logic [7:0]        cfg, w;       // Expected configuration and write value.
  int                err_count, cmp_count, s, p;

  aic_irq_status aic_irq_status_inst (.clk_i, .rst_i, .paddr_i, .psel_i, .penable_i,
    .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .transient_event_active_i(ev_q[0]), .new_orientation_flag_i(ev_q[1]),
    .tap_event_active_i(ev_q[2]), .fall_motion_event_active_i(ev_q[3]),
    .all_axes_new_sample_i(new_q), .all_axes_overwrite_i(ovw_q),
    .transient_source_reg_read_i(clr_q[0]), .orientation_status_reg_read_i(clr_q[1]),
    .tap_source_reg_read_i(clr_q[2]), .fall_motion_source_reg_read_i(clr_q[3]),
    .xyz_data_read_i(xyz_q), .raw_sample_i(raw_q), .hp_sample_i(hp_q),
    .sample_valid_i(val_q), .out_sample_o, .out_valid_o, .full_scale_select_o,
    .highpass_output_enable_o, .irq_o);
  aic_host_model aic_host_model_inst (.clk_i, .paddr_o(paddr_i), .psel_o(psel_i),
    .penable_o(penable_i), .pwrite_o(pwrite_i), .pwdata_o(pwdata_i),
    .prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o));

  // Clock at 40 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // One register access by index; a hung bus ends the run as a failure.
  task automatic acc(input logic wr, input logic [5:0] ix, input logic [7:0] d,
                     input logic [1:0] lo = 2'b00);
    aic_host_model_inst.xfer(wr, {ix, lo}, {24'h0, d}, rd, er, ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      complete_run();
    end
  endtask : acc

  // Expected configuration after a write; a reserved range keeps the old one.
  function automatic logic [7:0] exp_cfg(input logic [7:0] o, input logic [7:0] d);
    exp_cfg = d & CFG_WMASK;
    if (d[1:0] == FS_RSVD)
      exp_cfg[1:0] = o[1:0];
  endfunction : exp_cfg

  // Main sequence: reset state, registers, samples, then events and the interrupt.
  initial
  begin
    rst_i = 1'b1;
    {ev_q, clr_q, new_q, ovw_q, xyz_q, val_q, raw_q, hp_q} = '0;
    err_count = 0;
    cmp_count = 0;
    cfg = CFG_RST;
    s = $urandom(84);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("range", 0, full_scale_select_o);
    chk("hpf", 0, highpass_output_enable_o);
    acc(0, IDX_SRC, 0);
    chk("source", 0, rd);
    acc(1, IDX_ID, 8'hFF);
    chk("error", 0, er);
    acc(1, IDX_SRC, 8'hFF);
    chk("error", 0, er);
    acc(0, IDX_ID, 0);
    chk("id", PART_ID_D, rd);
    acc(0, IDX_SRC, 0);
    chk("source", 0, rd);
    // An unmapped index and a misaligned write both answer with an error.
    acc(0, 6'h3F, 0);
    chk("unmapped", 1, er);
    acc(1, IDX_CFG, 8'h13, 2'b01);
    chk("misaligned", 1, er);
    acc(0, IDX_CFG, 0);
    chk("cfg", cfg, rd);
    // Every range code first, then random settings, each with one sample through.
    for (int k = 0; k < 12; k++)
    begin
      w = 8'($urandom);
      if (k < 4)
        w[1:0] = 2'(k);
      acc(1, IDX_CFG, w);
      cfg = exp_cfg(cfg, w);
      acc(0, IDX_CFG, 0);
      chk("cfg", cfg, rd);
      chk("range", cfg[1:0], full_scale_select_o);
      chk("hpf", cfg[4], highpass_output_enable_o);
      raw_q <= DATA_W'($urandom);
      hp_q <= DATA_W'($urandom);
      val_q <= 1'b1;
      @(posedge clk_i);
      val_q <= 1'b0;
      #1;
      chk("sample", cfg[4] ? hp_q : raw_q, out_sample_o);
      chk("valid", 1, out_valid_o);
    end
    // A disabled engine records nothing.
    ev_q[0] <= 1'b1;
    acc(0, IDX_SRC, 0);
    chk("source", 0, rd);
    ev_q[0] <= 1'b0;
    acc(1, IDX_IEN, 8'h3D);
    acc(1, IDX_IMSK, 8'h3D);
    for (int i = 0; i < 4; i++)
    begin
      p = 5 - i;
      ev_q[i] <= 1'b1;
      repeat (2) @(posedge clk_i);
      acc(0, IDX_SRC, 0);
      chk("source", 32'd1 << p, rd);
      chk("irq", 1, irq_o);
      clr_q[i] <= 1'b1;
      @(posedge clk_i);
      clr_q[i] <= 1'b0;
      acc(0, IDX_SRC, 0);
      chk("source", 0, rd);
      ev_q[i] <= 1'b0;
      acc(1, IDX_ISTS, 8'h3D);
      acc(0, IDX_ISTS, 0);
      chk("status", 0, rd);
      chk("irq", 0, irq_o);
    end
    // Data ready, masked: a status read leaves it set, an axis read clears it.
    acc(1, IDX_IMSK, 8'h00);
    new_q <= 1'b1;
    @(posedge clk_i);
    new_q <= 1'b0;
    acc(0, IDX_SRC, 0);
    chk("source", 1, rd);
    acc(0, IDX_ISTS, 0);
    chk("status", 1, rd);
    chk("irq", 0, irq_o);
    acc(0, IDX_SRC, 0);
    chk("source", 1, rd);
    xyz_q <= 1'b1;
    @(posedge clk_i);
    xyz_q <= 1'b0;
    acc(0, IDX_SRC, 0);
    chk("source", 0, rd);
    ovw_q <= 1'b1;
    @(posedge clk_i);
    ovw_q <= 1'b0;
    acc(0, IDX_SRC, 0);
    chk("source", 1, rd);
    acc(1, IDX_IMSK, 8'h01);
    acc(0, IDX_SRC, 0);
    chk("irq", 1, irq_o);
    complete_run();
  end
endmodule : aic_irq_status_bench
